// File: common/unb_map.svh
`ifndef UNB_MAP_SVH
`define UNB_MAP_SVH

// Register byte offsets
`define UNB_OFF_SERIAL_CONTROL   8'h00
`define UNB_OFF_SERIAL_BUFFER    8'h04
`define UNB_OFF_POWER_CONTROL    8'h08
`define UNB_OFF_BOOT_CONFIG      8'h0C
`define UNB_OFF_T1_RELOAD        8'h10
`define UNB_OFF_T2_RELOAD_LOW    8'h14
`define UNB_OFF_T2_RELOAD_HIGH   8'h18
`define UNB_OFF_T2_CONTROL       8'h1C
`define UNB_OFF_STATUS           8'h20

// Field positions
`define UNB_SC_MODE_HI           7
`define UNB_SC_MODE_LO           6
`define UNB_SC_MP_EN             5
`define UNB_SC_RX_EN             4
`define UNB_SC_TX_B8             3
`define UNB_SC_RX_B8             2
`define UNB_SC_TX_DONE           1
`define UNB_SC_RX_DONE           0
`define UNB_PC_BAUD_DOUBLE       7
`define UNB_BC_CLOCK_MODE        6
`define UNB_T2_FLAG              7
`define UNB_T2_RX_SRC            5
`define UNB_T2_TX_SRC            4

// Reset values
`define UNB_RST_CLOCK_MODE       1'b1
`define UNB_RST_LINE             1'b1

// Timing counts
`define UNB_MC_LAST_TWELVE       4'hB
`define UNB_MC_LAST_SIX          4'h5
`define UNB_OSC_LAST_MAX         2'h3
`define UNB_T1_TOP               8'hFF
`define UNB_T2_TOP               16'hFFFF
`define UNB_TICK_HALF            4'h7
`define UNB_TICK_LAST            4'hF
`define UNB_RX_LAST_BIT          4'h8
`define UNB_TX_LAST_M1           4'h9
`define UNB_TX_LAST_M23          4'hA

`endif

// File: common/unb_pkg.sv
package unb_pkg;

	typedef enum logic [1:0] {
		UNB_RX_IDLE,
		UNB_RX_START,
		UNB_RX_DATA
	} unb_rx_state_t;

	typedef struct packed {
		logic [3:0]  presc;
		logic [7:0]  t1_cnt;
		logic        t1_half;
		logic [15:0] t2_cnt;
		logic        t2_ph;
		logic [1:0]  osc_cnt;
		logic        rx_tick;
		logic        tx_tick;
		logic        sh_tick;
		logic        t2_ovf;
	} unb_baud_t;

	typedef struct packed {
		logic [1:0]    mode;
		logic          multiproc_enable;
		logic          rx_enable;
		logic          tx_ninth_bit;
		logic          rx_ninth_bit;
		logic          transmit_done_flag;
		logic          receive_done_flag;
		logic [7:0]    rx_buf;
		logic          baud_double;
		logic          clock_mode_select;
		logic [7:0]    timer_one_reload_byte;
		logic [7:0]    timer_two_reload_low;
		logic [7:0]    timer_two_reload_high;
		logic          rx_clock_from_timer_two;
		logic          tx_clock_from_timer_two;
		logic          t2_flag;
		logic          s1;
		logic          s2;
		logic          rx_prev;
		unb_rx_state_t rx_st;
		logic [3:0]    rx_tk;
		logic [3:0]    rx_bit;
		logic [8:0]    rx_sh;
		logic          tx_busy;
		logic [3:0]    tx_tk;
		logic [3:0]    tx_bit;
		logic [10:0]   tx_sh;
		logic          tx_pin;
		logic          d_wr;
		logic [7:0]    d_addr;
		logic [31:0]   hrdata;
	} unb_core_t;

endpackage

// File: verilog/unb_baud.sv
`timescale 1ns/1ns
`default_nettype none
`include "unb_map.svh"

module unb_baud (
	input  wire logic        hclk,
	input  wire logic        hresetn,
	input  wire logic [1:0]  mode,
	input  wire logic        baud_double,
	input  wire logic        clock_mode_select,
	input  wire logic [7:0]  t1_reload,
	input  wire logic [15:0] t2_reload,
	input  wire logic        rx_src_t2,
	input  wire logic        tx_src_t2,
	output logic             rx_tick,
	output logic             tx_tick,
	output logic             sh_tick,
	output logic             t2_ovf
);

	unb_pkg::unb_baud_t r_reg;
	unb_pkg::unb_baud_t r_next;

	logic       mc_end;
	logic       t1_ovf;
	logic       t1_tick;
	logic       t2_step;
	logic       t2_wrap;
	logic       osc_tick;
	logic [1:0] osc_last;
	logic [1:0] osc_shift;

	always_comb begin
		r_next = r_reg;
		// Machine-cycle prescaler, also the mode 0 shift rate
		// At or past the end, so a switch to the short cycle never waits for a wrap
		mc_end = r_reg.presc >= (clock_mode_select ? `UNB_MC_LAST_TWELVE : `UNB_MC_LAST_SIX);
		r_next.presc = mc_end ? 4'h0 : r_reg.presc + 4'h1;
		// Auto-reload byte and the machine-cycle length set the overflow rate
		t1_ovf = mc_end && r_reg.t1_cnt == `UNB_T1_TOP;
		// A count below the reload is left from reset or a new reload; jump at once
		if (mc_end) begin
			r_next.t1_cnt = (t1_ovf || r_reg.t1_cnt < t1_reload) ? t1_reload : r_reg.t1_cnt + 8'h1;
		end
		r_next.t1_half = t1_ovf ? ~r_reg.t1_half : r_reg.t1_half;
		t1_tick = t1_ovf && (baud_double || r_reg.t1_half);
		// Timer 2 steps at osc/2 in twelve-clock mode, every clock in six-clock mode
		t2_step = clock_mode_select ? r_reg.t2_ph : 1'b1;
		r_next.t2_ph = ~r_reg.t2_ph;
		t2_wrap = t2_step && r_reg.t2_cnt == `UNB_T2_TOP;
		// Same jump, or a new rate could wait up to 65536 steps
		if (t2_step) begin
			r_next.t2_cnt = (t2_wrap || r_reg.t2_cnt < t2_reload) ? t2_reload : r_reg.t2_cnt + 16'h1;
		end
		// Oscillator-derived 16x tick for mode 2
		osc_shift = {1'b0, baud_double} + {1'b0, ~clock_mode_select};
		osc_last = 2'(`UNB_OSC_LAST_MAX >> osc_shift);
		osc_tick = r_reg.osc_cnt == osc_last;
		r_next.osc_cnt = osc_tick ? 2'h0 : r_reg.osc_cnt + 2'h1;
		// Mode 3 differs from mode 2 only in this source choice
		if (mode == 2'h2) begin
			r_next.rx_tick = osc_tick;
			r_next.tx_tick = osc_tick;
		end else begin
			r_next.rx_tick = rx_src_t2 ? t2_wrap : t1_tick;
			r_next.tx_tick = tx_src_t2 ? t2_wrap : t1_tick;
		end
		r_next.sh_tick = mc_end;
		r_next.t2_ovf = t2_wrap;
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			r_reg <= '0;
		end else begin
			r_reg <= r_next;
		end
	end

	assign rx_tick = r_reg.rx_tick;
	assign tx_tick = r_reg.tx_tick;
	assign sh_tick = r_reg.sh_tick;
	assign t2_ovf = r_reg.t2_ovf;

endmodule

`default_nettype wire

// File: verilog/unb_uart.sv
`timescale 1ns/1ns
`default_nettype none
`include "unb_map.svh"

module unb_uart (
	input  wire logic        hclk,
	input  wire logic        hresetn,
	input  wire logic        hsel,
	input  wire logic [31:0] haddr,
	input  wire logic [1:0]  htrans,
	input  wire logic        hwrite,
	input  wire logic [2:0]  hsize,
	input  wire logic [31:0] hwdata,
	input  wire logic        hready,
	output logic             hreadyout,
	output logic             hresp,
	output logic [31:0]      hrdata,
	input  wire logic        serial_rx_pin,
	output logic             serial_tx_pin,
	output logic             serial_irq,
	output logic             timer_two_irq,
	output logic             shift_clock_tick
);

	unb_pkg::unb_core_t r_reg;
	unb_pkg::unb_core_t r_next;

	logic       rx_tick;
	logic       tx_tick;
	logic       t2_ovf;
	logic       take;
	logic       fall;
	logic       t2_baud;
	logic [7:0] wd;
	logic [3:0] tx_last;

	// Read view of the register map; fed the next state so a read
	// right behind a write to the same register sees the new value
	function automatic logic [7:0] read_mux(
		input logic [7:0]         addr,
		input unb_pkg::unb_core_t s
	);
		logic [7:0] v;
		v = 8'h00;
		case (addr)
			`UNB_OFF_SERIAL_CONTROL: begin
				v = {s.mode, s.multiproc_enable, s.rx_enable, s.tx_ninth_bit,
					s.rx_ninth_bit, s.transmit_done_flag, s.receive_done_flag};
			end
			`UNB_OFF_SERIAL_BUFFER: begin
				v = s.rx_buf;
			end
			`UNB_OFF_POWER_CONTROL: begin
				v[`UNB_PC_BAUD_DOUBLE] = s.baud_double;
			end
			`UNB_OFF_BOOT_CONFIG: begin
				v[`UNB_BC_CLOCK_MODE] = s.clock_mode_select;
			end
			`UNB_OFF_T1_RELOAD: begin
				v = s.timer_one_reload_byte;
			end
			`UNB_OFF_T2_RELOAD_LOW: begin
				v = s.timer_two_reload_low;
			end
			`UNB_OFF_T2_RELOAD_HIGH: begin
				v = s.timer_two_reload_high;
			end
			`UNB_OFF_T2_CONTROL: begin
				v[`UNB_T2_FLAG] = s.t2_flag;
				v[`UNB_T2_RX_SRC] = s.rx_clock_from_timer_two;
				v[`UNB_T2_TX_SRC] = s.tx_clock_from_timer_two;
			end
			`UNB_OFF_STATUS: begin
				// Next-state edge stage holds the second synchroniser stage
				v = {5'h00, s.rx_prev, s.tx_busy, s.rx_st != unb_pkg::UNB_RX_IDLE};
			end
			default: begin
				v = 8'h00;
			end
		endcase
		return v;
	endfunction

	unb_baud u_baud (
		.hclk              (hclk),
		.hresetn           (hresetn),
		.mode              (r_reg.mode),
		.baud_double       (r_reg.baud_double),
		.clock_mode_select (r_reg.clock_mode_select),
		.t1_reload         (r_reg.timer_one_reload_byte),
		.t2_reload         ({r_reg.timer_two_reload_high, r_reg.timer_two_reload_low}),
		.rx_src_t2         (r_reg.rx_clock_from_timer_two),
		.tx_src_t2         (r_reg.tx_clock_from_timer_two),
		.rx_tick           (rx_tick),
		.tx_tick           (tx_tick),
		.sh_tick           (shift_clock_tick),
		.t2_ovf            (t2_ovf)
	);

	always_comb begin
		r_next = r_reg;
		wd = hwdata[7:0];
		take = hsel && htrans[1] && hready;
		t2_baud = r_reg.rx_clock_from_timer_two || r_reg.tx_clock_from_timer_two;
		tx_last = (r_reg.mode == 2'h1) ? `UNB_TX_LAST_M1 : `UNB_TX_LAST_M23;

		// Pin synchroniser; only the second stage feeds the edge detector
		r_next.s1 = serial_rx_pin;
		r_next.s2 = r_reg.s1;
		r_next.rx_prev = r_reg.s2;
		fall = r_reg.rx_prev && !r_reg.s2;

		// Bus address phase; every access is a single word
		r_next.d_wr = take && hwrite;
		r_next.d_addr = haddr[7:0];

		// Software writes land in the data phase
		if (r_reg.d_wr) begin
			case (r_reg.d_addr)
				`UNB_OFF_SERIAL_CONTROL: begin
					r_next.mode = wd[`UNB_SC_MODE_HI:`UNB_SC_MODE_LO];
					r_next.multiproc_enable = wd[`UNB_SC_MP_EN];
					r_next.rx_enable = wd[`UNB_SC_RX_EN];
					r_next.tx_ninth_bit = wd[`UNB_SC_TX_B8];
					r_next.rx_ninth_bit = wd[`UNB_SC_RX_B8];
					// Writing 1 keeps a flag, writing 0 clears it
					r_next.transmit_done_flag = r_reg.transmit_done_flag && wd[`UNB_SC_TX_DONE];
					r_next.receive_done_flag = r_reg.receive_done_flag && wd[`UNB_SC_RX_DONE];
				end
				`UNB_OFF_SERIAL_BUFFER: begin
					// A write while a frame is on the line is dropped
					if (!r_reg.tx_busy && r_reg.mode != 2'h0) begin
						r_next.tx_busy = 1'b1;
						r_next.tx_tk = 4'h0;
						r_next.tx_bit = 4'h0;
						// Start, data LSB first, ninth or stop, stop
						if (r_reg.mode == 2'h1) begin
							r_next.tx_sh = {2'b11, wd, 1'b0};
						end else begin
							r_next.tx_sh = {1'b1, r_reg.tx_ninth_bit, wd, 1'b0};
						end
					end
				end
				`UNB_OFF_POWER_CONTROL: begin
					r_next.baud_double = wd[`UNB_PC_BAUD_DOUBLE];
				end
				`UNB_OFF_BOOT_CONFIG: begin
					r_next.clock_mode_select = wd[`UNB_BC_CLOCK_MODE];
				end
				`UNB_OFF_T1_RELOAD: begin
					r_next.timer_one_reload_byte = wd;
				end
				`UNB_OFF_T2_RELOAD_LOW: begin
					r_next.timer_two_reload_low = wd;
				end
				`UNB_OFF_T2_RELOAD_HIGH: begin
					r_next.timer_two_reload_high = wd;
				end
				`UNB_OFF_T2_CONTROL: begin
					r_next.t2_flag = r_reg.t2_flag && wd[`UNB_T2_FLAG];
					r_next.rx_clock_from_timer_two = wd[`UNB_T2_RX_SRC];
					r_next.tx_clock_from_timer_two = wd[`UNB_T2_TX_SRC];
				end
				default: begin
					r_next.d_addr = r_next.d_addr;
				end
			endcase
		end

		// Timer 2 overflow flags only when it is not the baud source
		if (t2_ovf && !t2_baud) begin
			r_next.t2_flag = 1'b1;
		end

		// Receiver; mode 0 and a cleared enable hold it idle
		case (r_reg.rx_st)
			unb_pkg::UNB_RX_IDLE: begin
				// Falling edge opens a frame
				if (fall && r_reg.rx_enable && r_reg.mode != 2'h0) begin
					r_next.rx_st = unb_pkg::UNB_RX_START;
					r_next.rx_tk = 4'h0;
				end
			end
			unb_pkg::UNB_RX_START: begin
				if (rx_tick) begin
					r_next.rx_tk = r_reg.rx_tk + 4'h1;
					// Half a bit later the line must still be low
					if (r_reg.rx_tk == `UNB_TICK_HALF) begin
						r_next.rx_tk = 4'h0;
						r_next.rx_bit = 4'h0;
						if (r_reg.s2) begin
							r_next.rx_st = unb_pkg::UNB_RX_IDLE;
						end else begin
							r_next.rx_st = unb_pkg::UNB_RX_DATA;
						end
					end
				end
			end
			unb_pkg::UNB_RX_DATA: begin
				if (rx_tick) begin
					r_next.rx_tk = r_reg.rx_tk + 4'h1;
					// Sixteen ticks from one centre to the next
					if (r_reg.rx_tk == `UNB_TICK_LAST) begin
						r_next.rx_sh = {r_reg.s2, r_reg.rx_sh[8:1]};
						r_next.rx_bit = r_reg.rx_bit + 4'h1;
						// Ninth sample: ninth bit in modes 2/3, stop in 1
						if (r_reg.rx_bit == `UNB_RX_LAST_BIT) begin
							r_next.rx_st = unb_pkg::UNB_RX_IDLE;
							// Ninth bit separates address from data
							if (!r_reg.receive_done_flag &&
								(!r_reg.multiproc_enable || r_reg.s2)) begin
								r_next.rx_buf = r_reg.rx_sh[8:1];
								r_next.rx_ninth_bit = r_reg.s2;
								r_next.receive_done_flag = 1'b1;
							end
							// Otherwise nothing is loaded
						end
					end
				end
			end
			default: begin
				r_next.rx_st = unb_pkg::UNB_RX_IDLE;
			end
		endcase
		if (!r_reg.rx_enable || r_reg.mode == 2'h0) begin
			r_next.rx_st = unb_pkg::UNB_RX_IDLE;
		end

		// Transmitter: sixteen ticks per bit
		if (r_reg.tx_busy && tx_tick) begin
			r_next.tx_tk = r_reg.tx_tk + 4'h1;
			if (r_reg.tx_tk == `UNB_TICK_LAST) begin
				r_next.tx_sh = {1'b1, r_reg.tx_sh[10:1]};
				r_next.tx_bit = r_reg.tx_bit + 4'h1;
				// Flag rises after the full stop bit has been on the line
				if (r_reg.tx_bit == tx_last) begin
					r_next.tx_busy = 1'b0;
					r_next.transmit_done_flag = 1'b1;
				end
			end
		end
		r_next.tx_pin = r_next.tx_busy ? r_next.tx_sh[0] : `UNB_RST_LINE;

		// Read data registered at the address phase from the next state
		if (take && !hwrite) begin
			r_next.hrdata = {24'h000000, read_mux(haddr[7:0], r_next)};
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			r_reg <= '0;
			r_reg.clock_mode_select <= `UNB_RST_CLOCK_MODE;
			r_reg.s1 <= `UNB_RST_LINE;
			r_reg.s2 <= `UNB_RST_LINE;
			r_reg.rx_prev <= `UNB_RST_LINE;
			r_reg.tx_pin <= `UNB_RST_LINE;
		end else begin
			r_reg <= r_next;
		end
	end

	// Zero wait states; no error response exists
	assign hreadyout = 1'b1;
	assign hresp = 1'b0;
	assign hrdata = r_reg.hrdata;
	assign serial_tx_pin = r_reg.tx_pin;
	assign serial_irq = r_reg.receive_done_flag || r_reg.transmit_done_flag;
	assign timer_two_irq = r_reg.t2_flag;

endmodule

`default_nettype wire

// File: sim/unb_uart_chk.sv
`timescale 1ns/1ns
`default_nettype none
module unb_uart_chk (
	input wire logic        hclk,
	input wire logic        hresetn,
	input wire logic        hsel,
	input wire logic [1:0]  htrans,
	input wire logic        hwrite,
	input wire logic        hreadyout,
	input wire logic        hresp,
	input wire logic [31:0] hrdata,
	input wire logic        serial_irq,
	input wire logic        shift_clock_tick
);
	default clocking @(posedge hclk); endclocking
	default disable iff (!hresetn);
	logic [2:0] since_wr;
	// Flags fall only a couple of edges after a write address phase
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn)
			since_wr <= 3'h7;
		else if (hsel && htrans[1] && hwrite)
			since_wr <= 3'h0;
		else if (since_wr != 3'h7)
			since_wr <= since_wr + 3'h1;
	end
	sequence s_gap;
		(!shift_clock_tick) [*5];
	endsequence
	property p_okay;
		hresp == 1'b0;
	endproperty
	a_okay: assert property (p_okay) else $error("response not okay");
	property p_ready;
		hreadyout == 1'b1;
	endproperty
	a_ready: assert property (p_ready) else $error("wait state inserted");
	property p_hi_zero;
		hrdata[31:8] == 24'h0;
	endproperty
	a_hi_zero: assert property (p_hi_zero) else $error("upper read bits set");
	property p_hold;
		!$stable(hrdata) |-> $past(hsel && htrans[1] && !hwrite);
	endproperty
	a_hold: assert property (p_hold) else $error("read data moved without read");
	property p_irq_clr;
		$fell(serial_irq) |-> since_wr < 3'h3;
	endproperty
	a_irq_clr: assert property (p_irq_clr) else $error("flag cleared by hardware");
	property p_tick_gap;
		shift_clock_tick |=> s_gap;
	endproperty
	a_tick_gap: assert property (p_tick_gap) else $error("shift tick too close");
	property p_tick_next;
		shift_clock_tick |-> ##[6:12] shift_clock_tick;
	endproperty
	a_tick_next: assert property (p_tick_next) else $error("shift tick missing");
	property p_irq_rst;
		$rose(hresetn) |-> !serial_irq;
	endproperty
	a_irq_rst: assert property (p_irq_rst) else $error("flag set out of reset");
endmodule
`default_nettype wire

// File: sim/unb_node.sv
`timescale 1ns/1ns
`default_nettype none
module unb_node (
	input  wire logic clk,
	input  wire logic line_in,
	output logic      line_out
);
	// Line idles high, as a pulled-up wire would
	initial line_out = 1'b1;
	// Start 0, data LSB first, ninth bit, stop 1
	// Caller puts 1 in the ninth bit of address frames, 0 in data
	task automatic send(input logic [8:0] d, input int per);
		int i;
		line_out <= 1'b0;
		repeat (per) @(posedge clk);
		for (i = 0; i < 9; i++) begin
			line_out <= d[i];
			repeat (per) @(posedge clk);
		end
		line_out <= 1'b1;
		repeat (per) @(posedge clk);
	endtask
	// Returns {stop, ninth, data}, sampled at bit centres
	task automatic recv(input int per, output logic [9:0] q);
		int i;
		i = 0;
		while (line_in === 1'b1 && i < 4000) begin
			@(posedge clk);
			i++;
		end
		// No start bit within the bound: unknowns make the caller count a miss
		if (line_in === 1'b1) begin
			q = 'x;
			return;
		end
		repeat (per / 2) @(posedge clk);
		for (i = 0; i < 10; i++) begin
			repeat (per) @(posedge clk);
			q[i] = line_in;
		end
	endtask
endmodule
`default_nettype wire

// File: sim/unb_uart_tb.sv
`timescale 1ns/1ns
`default_nettype none
`include "unb_map.svh"
module unb_uart_tb;
	logic        hclk;
	logic        hresetn;
	logic        hsel;
	logic [31:0] haddr;
	logic [1:0]  htrans;
	logic        hwrite;
	logic [2:0]  hsize;
	logic [31:0] hwdata;
	logic        hreadyout;
	logic        hresp;
	logic [31:0] hrdata;
	logic        rx_line;
	logic        tx_line;
	logic        serial_irq;
	logic        timer_two_irq;
	logic        shift_clock_tick;
	logic [31:0] rd;
	logic [9:0]  got;
	int          n_errors;
	int          checks_done;
	initial hclk = 1'b0;
	always #50 hclk = ~hclk;
	unb_uart dut (
		.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
		.hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
		.hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .serial_rx_pin(rx_line),
		.serial_tx_pin(tx_line), .serial_irq(serial_irq), .timer_two_irq(timer_two_irq),
		.shift_clock_tick(shift_clock_tick)
	);
	unb_node node (.clk(hclk), .line_in(tx_line), .line_out(rx_line));
	task automatic wrap_up();
		$display("checks=%0d errors=%0d", checks_done, n_errors);
		if (n_errors == 0 && checks_done > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		checks_done++;
		if (seen !== exp) begin
			n_errors++;
			$display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask
	// Bounded wait; a hung bus ends the run
	task automatic wait_ready();
		int i;
		i = 0;
		do begin
			@(posedge hclk);
			i++;
		end while (hreadyout !== 1'b1 && i < 50);
		if (hreadyout !== 1'b1) begin
			n_errors++;
			wrap_up();
		end
	endtask
	// Called just after a rising edge; returns at one
	task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
		hsel <= 1'b1;
		haddr <= {24'h0, a};
		htrans <= 2'h2;
		hwrite <= w;
		wait_ready();
		hsel <= 1'b0;
		htrans <= 2'h0;
		hwdata <= d;
		wait_ready();
		rd = hrdata;
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		bus(1'b1, a, d);
	endtask
	task automatic rdc(input logic [7:0] a, input logic [31:0] exp);
		bus(1'b0, a, 32'h0);
		check(rd, exp);
	endtask
	initial begin
		hresetn = 1'b0;
		hsel = 1'b0;
		haddr = 32'h0;
		htrans = 2'h0;
		hwrite = 1'b0;
		hsize = 3'h2;
		hwdata = 32'h0;
		n_errors = 0;
		checks_done = 0;
		repeat (12) @(posedge hclk);
		hresetn <= 1'b1;
		@(posedge hclk);
		rdc(`UNB_OFF_SERIAL_CONTROL, 32'h0);
		rdc(`UNB_OFF_BOOT_CONFIG, 32'h40);
		rdc(8'h24, 32'h0);
		$display("reset test done");
		// Mode 2, twelve-clock mode, no doubling: 64 clocks a bit
		wr(`UNB_OFF_SERIAL_CONTROL, 32'h90);
		node.send(9'h1A5, 64);
		rdc(`UNB_OFF_SERIAL_CONTROL, 32'h95);
		rdc(`UNB_OFF_SERIAL_BUFFER, 32'hA5);
		node.send(9'h03C, 64);
		rdc(`UNB_OFF_SERIAL_BUFFER, 32'hA5);
		wr(`UNB_OFF_SERIAL_CONTROL, 32'h91);
		bus(1'b0, `UNB_OFF_SERIAL_CONTROL, 32'h0);
		check({31'h0, rd[0]}, 32'h1);
		$display("mode 2 test done");
		// Address filtering: data frame dropped, address frame right behind taken
		wr(`UNB_OFF_SERIAL_CONTROL, 32'hB0);
		node.send(9'h011, 64);
		rdc(`UNB_OFF_SERIAL_BUFFER, 32'hA5);
		check({31'h0, serial_irq}, 32'h0);
		bus(1'b0, `UNB_OFF_SERIAL_CONTROL, 32'h0);
		check(rd & 32'hFB, 32'hB0);
		node.send(9'h122, 64);
		rdc(`UNB_OFF_SERIAL_BUFFER, 32'h22);
		rdc(`UNB_OFF_SERIAL_CONTROL, 32'hB5);
		check({31'h0, serial_irq}, 32'h1);
		// Addressed slave clears multiproc_enable and takes a data frame
		wr(`UNB_OFF_SERIAL_CONTROL, 32'h90);
		node.send(9'h033, 64);
		rdc(`UNB_OFF_SERIAL_BUFFER, 32'h33);
		$display("filter test done");
		// Mode 3, Timer 1 reload FF doubled: overflow every 12 clocks, 192 a bit
		// Timer 1 has no interrupt here, so software has none to disable
		wr(`UNB_OFF_SERIAL_CONTROL, 32'hD0);
		wr(`UNB_OFF_POWER_CONTROL, 32'h80);
		wr(`UNB_OFF_T1_RELOAD, 32'hFF);
		node.send(9'h05A, 192);
		rdc(`UNB_OFF_SERIAL_BUFFER, 32'h5A);
		rdc(`UNB_OFF_SERIAL_CONTROL, 32'hD1);
		$display("timer one test done");
		// Timer 2 reload FFFF: one step of two clocks, 32 clocks a bit
		wr(`UNB_OFF_SERIAL_CONTROL, 32'hD8);
		wr(`UNB_OFF_T2_RELOAD_LOW, 32'hFF);
		wr(`UNB_OFF_T2_RELOAD_HIGH, 32'hFF);
		wr(`UNB_OFF_T2_CONTROL, 32'h30);
		node.send(9'h0C3, 32);
		rdc(`UNB_OFF_SERIAL_BUFFER, 32'hC3);
		fork
			node.recv(32, got);
			wr(`UNB_OFF_SERIAL_BUFFER, 32'h96);
		join
		check({22'h0, got}, 32'h396);
		// Flag is set at the end of the stop bit, half a bit after its centre
		repeat (32) @(posedge hclk);
		rdc(`UNB_OFF_SERIAL_CONTROL, 32'hDB);
		rdc(`UNB_OFF_T2_CONTROL, 32'h30);
		check({31'h0, timer_two_irq}, 32'h0);
		$display("timer two test done");
		// Mode 1, six-clock mode, Timer 2 at FFFF: a step each clock, 16 clocks a bit
		wr(`UNB_OFF_BOOT_CONFIG, 32'h0);
		wr(`UNB_OFF_SERIAL_CONTROL, 32'h70);
		node.send(9'h1E7, 16);
		rdc(`UNB_OFF_SERIAL_BUFFER, 32'hE7);
		rdc(`UNB_OFF_SERIAL_CONTROL, 32'h75);
		wr(`UNB_OFF_SERIAL_CONTROL, 32'h70);
		node.send(9'h018, 16);
		rdc(`UNB_OFF_SERIAL_CONTROL, 32'h70);
		rdc(`UNB_OFF_SERIAL_BUFFER, 32'hE7);
		fork
			node.recv(16, got);
			wr(`UNB_OFF_SERIAL_BUFFER, 32'h5C);
		join
		check({22'h0, got}, 32'h35C);
		$display("mode one test done");
		// Off the baud path Timer 2 wraps every clock and raises its flag
		wr(`UNB_OFF_T2_CONTROL, 32'h0);
		repeat (4) @(posedge hclk);
		rdc(`UNB_OFF_T2_CONTROL, 32'h80);
		check({31'h0, timer_two_irq}, 32'h1);
		$display("timer flag test done");
		wrap_up();
	end
endmodule
bind unb_uart unb_uart_chk chk (
	.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .htrans(htrans), .hwrite(hwrite),
	.hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .serial_irq(serial_irq),
	.shift_clock_tick(shift_clock_tick)
);
`default_nettype wire
